// *** rtl/rqs_pkg.sv ***
`default_nettype none
package rqs_pkg;
  // instance counts
  localparam int NUM_IN   = 4;
  localparam int NUM_OUT  = 4;
  localparam int NUM_LOOP = 3;
  localparam int NUM_PIN  = 2;
  localparam int NUM_SRC  = 8;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_MON  = 8'h08;
  localparam logic [7:0] A_NOM  = 8'h0c;
  localparam logic [7:0] A_FTHR = 8'h10;
  localparam logic [7:0] A_WIN  = 8'h14;
  localparam logic [7:0] A_PPS  = 8'h18;
  localparam logic [7:0] A_SEL  = 8'h1c;
  localparam logic [7:0] A_LOCK = 8'h20;
  localparam logic [7:0] A_STEP = 8'h24;
  localparam logic [7:0] A_HIST = 8'h28;
  localparam logic [7:0] A_DCO  = 8'h2c;
  localparam logic [7:0] A_OUT  = 8'h30;
  localparam logic [7:0] A_PIN  = 8'h34;
  localparam logic [7:0] A_INT  = 8'h38;
  // control bit positions
  localparam int C_SRST = 0;
  localparam int C_SYNC = 1;
  localparam int C_DCO  = 2;
  localparam int C_PINS = 3;
  localparam int C_HIST = 4;
  // output config field positions
  localparam int O_GRP  = 0;
  localparam int O_MA   = 8;
  localparam int O_MD   = 12;
  localparam int O_CASC = 16;
  // reset values
  localparam logic [19:0] RST_MON  = 20'h0ffff;
  localparam logic [15:0] RST_NOM  = 16'h0064;
  localparam logic [31:0] RST_FTHR = 32'h0004_0002;
  localparam logic [31:0] RST_WIN  = 32'h00c8_0032;
  localparam logic [31:0] RST_PPS  = 32'h000a_0004;
  localparam logic [31:0] RST_LOCK = 32'h2010_2010;
  // 1 us time base for the validation timer
  localparam int CLK_HZ   = 40_000_000;
  localparam int TICK_NS  = 1000;
  localparam int TICK_CYC = TICK_NS / (1_000_000_000 / CLK_HZ);
  // operating state after reset
  typedef enum logic [0:0] {
    RQS_IDLE = 1'b0,
    RQS_RUN  = 1'b1
  } rqs_run_e;
endpackage
`default_nettype wire

// *** rtl/rqs_ref_mon.sv ***
`default_nettype none
// qualifies one reference input from its edge timing
module rqs_ref_mon #(
  parameter int CW = 16
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          clr,
  input  wire logic          edge_p,
  input  wire logic          tick,
  input  wire logic [3:0]    mon_en,
  input  wire logic          pps_mode,
  input  wire logic [CW-1:0] nominal,
  input  wire logic [CW-1:0] thr_valid,
  input  wire logic [CW-1:0] thr_invalid,
  input  wire logic [CW-1:0] t_early,
  input  wire logic [CW-1:0] t_late,
  input  wire logic [CW-1:0] pps_jit,
  input  wire logic [CW-1:0] vtime,
  output logic               eligible,
  output logic               qualified
);
  typedef struct packed {
    logic [CW-1:0] per;   // cycles since last edge
    logic [CW-1:0] vt;    // validation time elapsed
    logic          fok;   // frequency in range
    logic          late;  // pulse missing
    logic          runt;  // pulse too early
    logic          pbad;  // 1pps phase off
    logic          elig;  // ready for selection
  } rqs_mon_s;
  rqs_mon_s r;       // state
  rqs_mon_s next_r;  // next state
  logic [CW-1:0] dev;  // distance of period from nominal
  logic          qual; // all enabled monitors agree
  // period deviation and combined qualification
  always_comb begin
    dev = (r.per > nominal) ? r.per - nominal : nominal - r.per;
    qual = (!mon_en[0] || r.fok) && (!mon_en[1] || !r.late) &&
           (!mon_en[2] || !r.runt) && (!mon_en[3] || !r.pbad);
  end
  // next state
  always_comb begin
    next_r = r;
    if (r.per != '1) begin
      next_r.per = r.per + 1'b1;
    end
    if (r.per > t_late) begin
      next_r.late = 1'b1;
    end
    if (edge_p) begin
      next_r.per  = '0;
      next_r.late = 1'b0;
      next_r.runt = r.per < t_early;
      next_r.pbad = pps_mode && (dev > pps_jit);
      if (dev <= thr_valid) begin
        next_r.fok = 1'b1;
      end else if (dev > thr_invalid) begin
        next_r.fok = 1'b0;
      end
    end
    // validation timer restarts on any disqualification
    if (!qual) begin
      next_r.vt   = '0;
      next_r.elig = 1'b0;
    end else if (r.vt >= vtime) begin
      next_r.elig = 1'b1;
    end else if (tick) begin
      next_r.vt = r.vt + 1'b1;
    end
    if (clr) begin
      next_r = '0;
    end
  end
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign eligible  = r.elig;
  assign qualified = qual;
endmodule
`default_nettype wire

// *** rtl/rqs_top.sv ***
// Our own choices: the register addresses and the AHB-Lite register port.
`default_nettype none
// supervision and control of the reference, loop and output logic
module rqs_top #(
  parameter int NIN  = rqs_pkg::NUM_IN,
  parameter int NOUT = rqs_pkg::NUM_OUT,
  parameter int NLP  = rqs_pkg::NUM_LOOP
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [7:0]      haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic [31:0]          hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire logic            interface_select_strap_pin,
  input  wire logic            freq_step_trigger,
  input  wire logic            freq_step_direction,
  input  wire logic [NIN-1:0]  ref_in,
  input  wire logic            apll_locked,
  input  wire logic [15:0]     loop_freq_err,
  input  wire logic [15:0]     loop_phase_err,
  input  wire logic [23:0]     tuning_word,
  output logic                 host_if_spi,
  output logic                 running,
  output logic [NLP-1:0]       loop_ref_cascade,
  output logic [1:0]           ref_select,
  output logic                 ref_select_valid,
  output logic [31:0]          dco_offset,
  output logic [NOUT-1:0]      out_div_reset,
  output logic [NOUT-1:0]      out_mute,
  output logic [1:0]           status_pin_o,
  output logic [1:0]           status_pin_oe,
  output logic                 int_flag
);
  typedef struct packed {
    rqs_pkg::rqs_run_e run;  // idle until soft reset
    logic            strap;  // strap captured once
    logic            spi;    // host interface choice
    logic [1:0]      st_s;   // strap synchroniser
    logic [2:0]      tg_s;   // trigger sync and delay
    logic [1:0]      dr_s;   // direction synchroniser
    logic [NIN-1:0]  rf1;    // ref sync stage 1
    logic [NIN-1:0]  rf2;    // ref sync stage 2
    logic [NIN-1:0]  rf3;    // ref edge delay
    logic [1:0]      al_s;   // analog lock synchroniser
    logic [5:0]      tcnt;   // time base divider
    logic            tick;   // 1 us enable
    logic [4:0]      ctrl;   // control bits
    logic [19:0]     mon;    // monitor enables, pps
    logic [15:0]     nom;    // nominal period
    logic [31:0]     fthr;   // invalid, valid thresholds
    logic [31:0]     win;    // late, early windows
    logic [31:0]     pps;    // validation time, jitter
    logic [10:0]     selc;   // priorities, manual, mode
    logic [31:0]     lock;   // lock thresholds
    logic [23:0]     step;   // step size in ppb
    logic [23:0]     hist;   // tuning word history
    logic [31:0]     dco;    // accumulated offset
    logic [16:0]     outc;   // groups, mutes, cascade
    logic [9:0]      pinc;   // status pin setup
    logic [7:0]      intc;   // polarity, mask
    logic            flock;  // frequency locked
    logic            plock;  // phase locked
    logic [1:0]      sel;    // selected input
    logic            selv;   // selection valid
    logic [NOUT-1:0] divr;   // divider reset
    logic [NOUT-1:0] mute;   // muted outputs
    logic [1:0]      pv;     // status pin values
    logic            intf;   // interrupt flag
    logic            rdp;    // read data phase
    logic            wrp;    // write data phase
    logic [7:0]      addr;   // latched address
    logic [31:0]     rdat;   // read data
  } rqs_top_s;
  rqs_top_s r;       // state
  rqs_top_s next_r;  // next state
  logic [NIN-1:0]  elig;    // inputs ready for selection
  logic [NIN-1:0]  qual;    // inputs currently qualified
  localparam int NUM_SRC = rqs_pkg::NUM_SRC;
  logic [NUM_SRC-1:0] src;  // interrupt sources
  logic [NUM_SRC-1:0] sig;  // status signal set
  logic [31:0]     rmux;    // register read value
  logic            pick_ok; // a candidate exists
  logic [1:0]      pick;    // best candidate
  logic [1:0]      best;    // best priority seen
  logic            trig_p;  // step trigger edge
  logic [2:0]      ps;      // status pin selector
  // per-input monitors
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_mon
      rqs_ref_mon #(.CW(16)) rqs_ref_mon_i (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .clr         (r.run == rqs_pkg::RQS_IDLE),
        .edge_p      (r.rf2[gi] & ~r.rf3[gi]),
        .tick        (r.tick),
        .mon_en      (r.mon[4*gi +: 4]),
        .pps_mode    (r.mon[16 + gi]),
        .nominal     (r.nom),
        .thr_valid   (r.fthr[15:0]),
        .thr_invalid (r.fthr[31:16]),
        .t_early     (r.win[15:0]),
        .t_late      (r.win[31:16]),
        .pps_jit     (r.pps[15:0]),
        .vtime       (r.pps[31:16]),
        .eligible    (elig[gi]),
        .qualified   (qual[gi])
      );
    end
  endgenerate
  // lowest priority value among eligible inputs wins, index breaks ties
  always_comb begin
    pick_ok = 1'b0;
    pick    = 2'h0;
    best    = 2'h3;
    for (int i = 0; i < NIN; i++) begin
      if (elig[i] && (!pick_ok || r.selc[3+2*i +: 2] < best)) begin
        pick_ok = 1'b1;
        pick    = 2'(i);
        best    = r.selc[3+2*i +: 2];
      end
    end
  end
  // interrupt sources and status signals
  always_comb begin
    src = {~r.al_s[1], ~r.plock, ~r.flock, ~r.selv, ~elig};
    sig = {r.intf, r.al_s[1], r.plock, r.flock, r.selv, elig[2:0]};
    trig_p = r.tg_s[1] & ~r.tg_s[2];
  end
  // register read multiplexer
  always_comb begin
    rmux = 32'h0000_0000;
    if (r.addr == rqs_pkg::A_CTRL) begin
      rmux[4:0] = r.ctrl;
    end else if (r.addr == rqs_pkg::A_STAT) begin
      rmux = {16'h0000, r.flock, r.plock, r.selv, r.sel, r.al_s[1],
              r.run, r.spi, qual, elig};
    end else if (r.addr == rqs_pkg::A_MON) begin
      rmux[19:0] = r.mon;
    end else if (r.addr == rqs_pkg::A_NOM) begin
      rmux[15:0] = r.nom;
    end else if (r.addr == rqs_pkg::A_FTHR) begin
      rmux = r.fthr;
    end else if (r.addr == rqs_pkg::A_WIN) begin
      rmux = r.win;
    end else if (r.addr == rqs_pkg::A_PPS) begin
      rmux = r.pps;
    end else if (r.addr == rqs_pkg::A_SEL) begin
      rmux[10:0] = r.selc;
    end else if (r.addr == rqs_pkg::A_LOCK) begin
      rmux = r.lock;
    end else if (r.addr == rqs_pkg::A_STEP) begin
      rmux[23:0] = r.step;
    end else if (r.addr == rqs_pkg::A_HIST) begin
      rmux[23:0] = r.hist;
    end else if (r.addr == rqs_pkg::A_DCO) begin
      rmux = r.dco;
    end else if (r.addr == rqs_pkg::A_OUT) begin
      rmux[16:0] = r.outc;
    end else if (r.addr == rqs_pkg::A_PIN) begin
      rmux[9:0] = r.pinc;
    end else if (r.addr == rqs_pkg::A_INT) begin
      rmux[7:0] = r.intc;
    end
  end
  // next state
  always_comb begin
    next_r = r;
    ps = 3'h0;
    // synchronisers: stage 1 only feeds stage 2
    next_r.st_s = {r.st_s[0], interface_select_strap_pin};
    next_r.tg_s = {r.tg_s[1:0], freq_step_trigger};
    next_r.dr_s = {r.dr_s[0], freq_step_direction};
    next_r.rf1  = ref_in;
    next_r.rf2  = r.rf1;
    next_r.rf3  = r.rf2;
    next_r.al_s = {r.al_s[0], apll_locked};
    // strap caught once, two cycles after reset release
    if (!r.strap && r.tcnt == 6'h02) begin
      next_r.strap = 1'b1;
      next_r.spi   = r.st_s[1];
    end
    // 1 us time base
    next_r.tick = 1'b0;
    if (r.tcnt == 6'(rqs_pkg::TICK_CYC - 1)) begin
      next_r.tcnt = 6'h00;
      next_r.tick = 1'b1;
    end else begin
      next_r.tcnt = r.tcnt + 6'h01;
    end
    // soft reset bit starts operation, then clears itself
    next_r.ctrl[rqs_pkg::C_SRST] = 1'b0;
    if (r.ctrl[rqs_pkg::C_SRST]) begin
      next_r.run   = rqs_pkg::RQS_RUN;
      next_r.dco   = 32'h0000_0000;
      next_r.flock = 1'b0;
      next_r.plock = 1'b0;
    end
    // selection: auto by priority or manual, valid only when eligible
    if (r.run == rqs_pkg::RQS_RUN) begin
      if (r.selc[0]) begin
        next_r.sel  = r.selc[2:1];
        next_r.selv = elig[r.selc[2:1]];
      end else begin
        next_r.sel  = pick_ok ? pick : r.sel;
        next_r.selv = pick_ok;
      end
    end
    // lock detectors with hysteresis
    if (!r.selv) begin
      next_r.flock = 1'b0;
      next_r.plock = 1'b0;
    end else begin
      if (loop_freq_err[15:8] <= r.lock[7:0]) begin
        next_r.flock = 1'b1;
      end else if (loop_freq_err[15:8] > r.lock[15:8]) begin
        next_r.flock = 1'b0;
      end
      if (loop_phase_err[15:8] <= r.lock[23:16]) begin
        next_r.plock = 1'b1;
      end else if (loop_phase_err[15:8] > r.lock[31:24]) begin
        next_r.plock = 1'b0;
      end
    end
    // tuning word history sampled each microsecond while frequency locked
    if (r.ctrl[rqs_pkg::C_HIST] && r.tick && r.flock) begin
      next_r.hist = tuning_word;
    end
    // frequency steps from the trigger pin
    if (r.ctrl[rqs_pkg::C_DCO] && r.ctrl[rqs_pkg::C_PINS] && trig_p) begin
      if (r.dr_s[1]) begin
        next_r.dco = r.dco - {8'h00, r.step};
      end else begin
        next_r.dco = r.dco + {8'h00, r.step};
      end
    end
    // sync bit holds grouped dividers, release aligns them
    for (int i = 0; i < NOUT; i++) begin
      next_r.divr[i] = r.ctrl[rqs_pkg::C_SYNC] &&
                       (r.outc[rqs_pkg::O_GRP+2*i +: 2] != 2'h0);
      next_r.mute[i] = (r.run == rqs_pkg::RQS_IDLE) ||
        (r.outc[rqs_pkg::O_MA+i] && !r.al_s[1]) ||
        (r.outc[rqs_pkg::O_MD+i] && !r.flock);
    end
    // status pins from registered signals
    for (int p = 0; p < 2; p++) begin
      ps = r.pinc[5*p +: 3];
      next_r.pv[p] = sig[ps] ^ r.pinc[5*p+3];
    end
    next_r.intf = (|(src[6:0] & r.intc[6:0])) ^ r.intc[7];
    // bus data phase: writes land, reads load data
    if (r.wrp) begin
      next_r.wrp = 1'b0;
      if (r.addr == rqs_pkg::A_CTRL) begin
        next_r.ctrl = hwdata[4:0];
      end else if (r.addr == rqs_pkg::A_MON) begin
        next_r.mon = hwdata[19:0];
      end else if (r.addr == rqs_pkg::A_NOM) begin
        next_r.nom = hwdata[15:0];
      end else if (r.addr == rqs_pkg::A_FTHR) begin
        next_r.fthr = hwdata;
      end else if (r.addr == rqs_pkg::A_WIN) begin
        next_r.win = hwdata;
      end else if (r.addr == rqs_pkg::A_PPS) begin
        next_r.pps = hwdata;
      end else if (r.addr == rqs_pkg::A_SEL) begin
        next_r.selc = hwdata[10:0];
      end else if (r.addr == rqs_pkg::A_LOCK) begin
        next_r.lock = hwdata;
      end else if (r.addr == rqs_pkg::A_STEP) begin
        next_r.step = hwdata[23:0];
      end else if (r.addr == rqs_pkg::A_OUT) begin
        next_r.outc = hwdata[16:0];
      end else if (r.addr == rqs_pkg::A_PIN) begin
        next_r.pinc = hwdata[9:0];
      end else if (r.addr == rqs_pkg::A_INT) begin
        next_r.intc = hwdata[7:0];
      end
    end
    if (r.rdp) begin
      next_r.rdp  = 1'b0;
      next_r.rdat = rmux;
    end
    // address phase accepted when the bus is ready
    if (hready && hsel && htrans[1]) begin
      next_r.addr = {haddr[7:2], 2'b00};
      next_r.wrp  = hwrite;
      next_r.rdp  = !hwrite;
    end
  end
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r      <= '0;
      r.mon  <= rqs_pkg::RST_MON;
      r.nom  <= rqs_pkg::RST_NOM;
      r.fthr <= rqs_pkg::RST_FTHR;
      r.win  <= rqs_pkg::RST_WIN;
      r.pps  <= rqs_pkg::RST_PPS;
      r.lock <= rqs_pkg::RST_LOCK;
      r.mute <= '1;
    end else begin
      r <= next_r;
    end
  end
  // outputs
  assign hrdata           = r.rdat;
  assign hreadyout        = !r.rdp;
  assign hresp            = 1'b0;
  assign host_if_spi      = r.spi;
  assign running          = (r.run == rqs_pkg::RQS_RUN);
  assign loop_ref_cascade = {NLP{r.outc[rqs_pkg::O_CASC]}};
  assign ref_select       = r.sel;
  assign ref_select_valid = r.selv;
  assign dco_offset       = r.dco;
  assign out_div_reset    = r.divr;
  assign out_mute         = r.mute;
  // open drain pulls low only; push-pull always drives
  assign status_pin_o  = r.pv & ~{r.pinc[9], r.pinc[4]};
  assign status_pin_oe = ~({r.pinc[9], r.pinc[4]} & r.pv);
  assign int_flag      = r.intf;
endmodule
`default_nettype wire

// *** testbench/rqs_top_properties.sv ***
`default_nettype none
// bus timing and status relations watched at the block ports
module rqs_top_properties #(
  parameter int NIN  = 4,
  parameter int NOUT = 4,
  parameter int NLP  = 3
) (
  input wire logic            hclk,
  input wire logic            hresetn,
  input wire logic            hsel,
  input wire logic [7:0]      haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic [31:0]     hwdata,
  input wire logic            hready,
  input wire logic [31:0]     hrdata,
  input wire logic            hreadyout,
  input wire logic            hresp,
  input wire logic            interface_select_strap_pin,
  input wire logic            freq_step_trigger,
  input wire logic            host_if_spi,
  input wire logic            running,
  input wire logic [31:0]     dco_offset,
  input wire logic [NOUT-1:0] out_div_reset,
  input wire logic [NOUT-1:0] out_mute
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic take;    // request taken at this edge
  logic ctrl_dp; // control write in its data phase
  logic srst_go; // soft reset bit being written
  assign take    = hsel & hready & htrans[1];
  assign srst_go = ctrl_dp & hwdata[0];
  // remember a control write until its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_dp <= 1'b0;
    end else if (hready) begin
      ctrl_dp <= take & hwrite & (haddr[7:2] == 6'h0);
    end
  end
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_write_nowait: assert property (
    take && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_read_onewait: assert property (
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_rdata_hold: assert property (
    $changed(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("read data moved without a read");
  chk_start_cause: assert property (
    $rose(running) |-> $past(srst_go) || $past(srst_go, 2)
    || $past(srst_go, 3))
    else $error("started without soft reset");
  chk_idle_muted: assert property (!running |-> &out_mute)
    else $error("output live while idle");
  chk_strap_held: assert property (
    $changed(host_if_spi) |->
    host_if_spi == $past(interface_select_strap_pin, 3))
    else $error("interface select differs from strap");
  chk_step_cause: assert property (
    $changed(dco_offset) && dco_offset != 32'h0 |->
    $past(freq_step_trigger, 2) || $past(freq_step_trigger, 3))
    else $error("offset moved without trigger");
  chk_sync_release: assert property (
    |($past(out_div_reset) & ~out_div_reset) |-> out_div_reset == '0)
    else $error("sync group released apart");
  cover property ($rose(running));
  cover property ($changed(dco_offset));
  cover property ($fell(|out_div_reset));
endmodule
bind rqs_top rqs_top_properties #(.NIN(NIN), .NOUT(NOUT), .NLP(NLP))
  rqs_top_properties_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .interface_select_strap_pin, .freq_step_trigger, .host_if_spi,
  .running, .dco_offset, .out_div_reset, .out_mute);
`default_nettype wire

// *** testbench/rqs_host_model.sv ***
`default_nettype none
// host side of the register bus, single word transfers
module rqs_host_model (
  input  wire logic        hclk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [7:0]       haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle at time zero
  initial begin
    hsel   = 1'b1;
    hsize  = 3'h2;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr  = 8'h00;
    hwdata = 32'h0;
  end
  // address phase held until taken, then data phase until ready
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
endmodule
`default_nettype wire

// *** testbench/ref_qualify_status_control_test.sv ***
`default_nettype none
// self-checking bench for the supervision block
module ref_qualify_status_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans, ref_select, status_pin_o, status_pin_oe;
  logic [2:0]  hsize, loop_ref_cascade;
  logic [31:0] hwdata, hrdata, dco_offset;
  logic        interface_select_strap_pin, freq_step_trigger;
  logic        freq_step_direction, apll_locked, host_if_spi;
  logic        running, ref_select_valid, int_flag;
  logic [3:0]  ref_in, out_div_reset, out_mute;
  logic [15:0] loop_freq_err, loop_phase_err;
  logic [23:0] tuning_word;
  int          failures = 0;
  int          n_compared = 0;
  int          per [4] = '{default: 0}; // reference period, 0 stops
  int          cnt [4] = '{default: 0};
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
  } rqs_row_s;
  // register cases: address, write flag, data, expected read
  rqs_row_s rows [10] = '{
    '{rqs_pkg::A_MON, 1'b0, 32'h0, {12'h0, rqs_pkg::RST_MON}},
    '{rqs_pkg::A_NOM, 1'b0, 32'h0, {16'h0, rqs_pkg::RST_NOM}},
    '{rqs_pkg::A_FTHR, 1'b0, 32'h0, rqs_pkg::RST_FTHR},
    '{rqs_pkg::A_WIN, 1'b0, 32'h0, rqs_pkg::RST_WIN},
    '{rqs_pkg::A_PPS, 1'b0, 32'h0, rqs_pkg::RST_PPS},
    '{rqs_pkg::A_LOCK, 1'b0, 32'h0, rqs_pkg::RST_LOCK},
    '{8'h3c, 1'b1, 32'h5a5a5a5a, 32'h0},
    '{rqs_pkg::A_DCO, 1'b1, 32'h0000ffff, 32'h0},
    '{rqs_pkg::A_STEP, 1'b1, 32'h5, 32'h5},
    '{rqs_pkg::A_CTRL, 1'b1, 32'h0, 32'h0}};
  assign hready = hreadyout;
  rqs_top rqs_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .interface_select_strap_pin, .freq_step_trigger,
    .freq_step_direction, .ref_in, .apll_locked, .loop_freq_err,
    .loop_phase_err, .tuning_word, .host_if_spi, .running,
    .loop_ref_cascade, .ref_select, .ref_select_valid, .dco_offset,
    .out_div_reset, .out_mute, .status_pin_o, .status_pin_oe,
    .int_flag);
  rqs_host_model rqs_host_model_i (.hclk, .hreadyout, .hrdata, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata);
  // 40 MHz clock
  always #12.5 hclk = ~hclk;
  // reference clocks, held low while stopped
  always @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] = (cnt[i] + 1 >= per[i]) ? 0 : cnt[i] + 1;
      ref_in[i] <= (per[i] != 0) && (cnt[i] < per[i] / 2);
    end
  end
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    rqs_host_model_i.xfer(a, 1'b1, d, r);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] r;
    rqs_host_model_i.xfer(a, 1'b0, 32'h0, r);
    chk(n, e, r);
  endtask
  // poll one status bit, bounded by lim reads
  task automatic wait_stat(input int b, input logic v, input int lim);
    logic [31:0] r;
    for (int k = 0; k < lim; k++) begin
      rqs_host_model_i.xfer(rqs_pkg::A_STAT, 1'b0, 32'h0, r);
      if (r[b] === v) break;
    end
    chk("status bit", 32'(v), 32'(r[b]));
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // one trigger pulse on the step pins
  task automatic step(input logic dn);
    @(posedge hclk);
    freq_step_direction <= dn;
    @(posedge hclk);
    freq_step_trigger <= 1'b1;
    repeat (3) @(posedge hclk);
    freq_step_trigger <= 1'b0;
    settle(6);
  endtask
  // outputs held while reset is low
  task automatic rst_chk();
    chk("reset mute", 32'hf, 32'(out_mute));
    chk("reset run", 32'h0, 32'(running));
    chk("reset pin oe", 32'h3, 32'(status_pin_oe));
    chk("reset rdata", 32'h0, hrdata);
  endtask
  initial begin
    #(60000 * 25);
    failures++;
    finish_test();
  end
  // main sequence
  initial begin
    hresetn = 1'b0;
    interface_select_strap_pin = 1'b1;
    freq_step_trigger = 1'b0;
    freq_step_direction = 1'b0;
    apll_locked = 1'b1;
    loop_freq_err = 16'hffff;
    loop_phase_err = 16'h0;
    tuning_word = 24'h00abcd;
    settle(5);
    rst_chk();
    @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd_chk("register", rows[i].a, rows[i].e);
    end
    chk("spi select", 32'h1, 32'(host_if_spi));
    wr(rqs_pkg::A_OUT, 32'h00011005);
    wr(rqs_pkg::A_CTRL, 32'h2);
    settle(2);
    chk("sync hold", 32'h3, 32'(out_div_reset));
    wr(rqs_pkg::A_CTRL, 32'h3);
    settle(3);
    chk("running", 32'h1, 32'(running));
    rd_chk("srst clears", rqs_pkg::A_CTRL, 32'h2);
    wr(rqs_pkg::A_CTRL, 32'h0);
    settle(2);
    chk("sync release", 32'h0, 32'(out_div_reset));
    chk("cascade", 32'h7, 32'(loop_ref_cascade));
    chk("mute on loss", 32'h1, 32'(out_mute));
    per[0] = 100;
    per[1] = 100;
    wait_stat(0, 1'b0, 1);
    wait_stat(0, 1'b1, 400);
    wait_stat(1, 1'b1, 400);
    chk("auto sel", 32'h0, 32'(ref_select));
    chk("sel valid", 32'h1, 32'(ref_select_valid));
    loop_freq_err <= 16'h0800;
    wait_stat(15, 1'b1, 20);
    wait_stat(14, 1'b1, 20);
    chk("unmute", 32'h0, 32'(out_mute));
    wr(rqs_pkg::A_CTRL, 32'h10);
    settle(44);
    rd_chk("history", rqs_pkg::A_HIST, 32'h00abcd);
    loop_freq_err <= 16'h1800;
    settle(3);
    wait_stat(15, 1'b1, 1);
    loop_freq_err <= 16'h2100;
    wait_stat(15, 1'b0, 20);
    wr(rqs_pkg::A_SEL, 32'h798);
    settle(3);
    chk("priority sel", 32'h1, 32'(ref_select));
    wr(rqs_pkg::A_SEL, 32'h5);
    settle(3);
    chk("manual sel", 32'h2, 32'(ref_select));
    wr(rqs_pkg::A_INT, 32'h4);
    settle(2);
    chk("int set", 32'h1, 32'(int_flag));
    wr(rqs_pkg::A_INT, 32'h1);
    settle(2);
    chk("int masked", 32'h0, 32'(int_flag));
    wr(rqs_pkg::A_INT, 32'h81);
    settle(2);
    chk("int invert", 32'h1, 32'(int_flag));
    chk("pin level", 32'h1, 32'(status_pin_o[0]));
    wr(rqs_pkg::A_PIN, 32'h8);
    settle(2);
    chk("pin invert", 32'h0, 32'(status_pin_o[0]));
    wr(rqs_pkg::A_PIN, 32'h10);
    settle(2);
    chk("pin released", 32'h0, 32'(status_pin_oe[0]));
    wr(rqs_pkg::A_PIN, 32'h7);
    settle(2);
    chk("pin int", 32'h1, 32'(status_pin_o[0]));
    per[0] = 0;
    wait_stat(0, 1'b0, 100);
    per[0] = 30;
    wr(rqs_pkg::A_MON, 32'h0fff4);
    settle(300);
    wait_stat(0, 1'b0, 1);
    wr(rqs_pkg::A_MON, 32'h0fff0);
    wait_stat(0, 1'b1, 400);
    wr(rqs_pkg::A_CTRL, 32'hc);
    step(1'b0);
    chk("step up", 32'h5, dco_offset);
    step(1'b1);
    step(1'b1);
    rd_chk("step down", rqs_pkg::A_DCO, 32'hfffffffb);
    wr(rqs_pkg::A_CTRL, 32'h4);
    step(1'b0);
    chk("pins off", 32'hfffffffb, dco_offset);
    hresetn <= 1'b0;
    interface_select_strap_pin <= 1'b0;
    settle(2);
    rst_chk();
    hresetn <= 1'b1;
    settle(6);
    chk("i2c select", 32'h0, 32'(host_if_spi));
    finish_test();
  end
endmodule
`default_nettype wire
